// >>> design/svi_pkg.sv
// shared constants and types for the vectored interrupt unit
package svi_pkg;
  localparam int NUM_SRC = 6;
  localparam logic [7:0] ADDR_CTRL_FIRST  = 8'h0B;
  localparam logic [7:0] ADDR_CTRL_SECOND = 8'h1E;
  localparam logic [7:0] RESET_CTRL_FIRST  = 8'h00;
  localparam logic [7:0] RESET_CTRL_SECOND = 8'h00;
  // first register fields
  localparam int POS_GLOBAL_EN  = 0;
  localparam int POS_EXT0_EN    = 1;
  localparam int POS_EXT1_EN    = 2;
  localparam int POS_TIMER0_EN  = 3;
  localparam int POS_EXT0_PEND  = 4;
  localparam int POS_EXT1_PEND  = 5;
  localparam int POS_TIMER0_PEND = 6;
  // second register fields
  localparam int POS_TIMER1_EN  = 0;
  localparam int POS_TBASE_EN   = 1;
  localparam int POS_RTC_EN     = 2;
  localparam int POS_TIMER1_PEND = 4;
  localparam int POS_TBASE_PEND = 5;
  localparam int POS_RTC_PEND   = 6;
  // vectors, index = source in priority order
  localparam logic [11:0] VEC_EXT0   = 12'h004;
  localparam logic [11:0] VEC_EXT1   = 12'h008;
  localparam logic [11:0] VEC_TIMER0 = 12'h00C;
  localparam logic [11:0] VEC_TIMER1 = 12'h010;
  localparam logic [11:0] VEC_TBASE  = 12'h014;
  localparam logic [11:0] VEC_RTC    = 12'h018;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } svi_mem_req_t;

  typedef struct packed {
    logic        take;
    logic [11:0] vector;
    logic [2:0]  source;
  } svi_call_t;
endpackage

// >>> design/svi_unit.sv
// six source vectored interrupt unit with control registers
// Notes on behaviour
// - bit 0 of first register enables all
// - first register bits 1-3 enable sources
// - first register bits 4-6 pending, bit 7 zero
// - second register bits 0-2 enable, bit 3 zero
// - second register bits 4-6 pending, bit 7 zero
// - falling pin edge sets external pending flag
// - only program counter pushed on accept
// - external sources vector to 04H and 08H
// - timer overflows vector to 0CH and 10H
// - time base 14H, real time clock 18H
// - accept clears pending flag and global enable
// - nesting held until return or reenable
// - interrupt return sets global enable again
// - requests sampled at phase-two pulse
// - fixed priority external 0 highest, rtc lowest
// - flags recorded while disabled, kept until cleared
// - registers at data addresses 0BH and 1EH
// - no acknowledge while return stack full
`timescale 1ns/1ps
module svi_unit (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire svi_pkg::svi_mem_req_t mem_req,
  output logic [7:0]                rdata_q,
  output logic                      rvalid_q,
  input  wire logic                 ext_pin_a,
  input  wire logic                 ext_pin_b,
  input  wire logic                 timer0_overflow,
  input  wire logic                 timer1_overflow,
  input  wire logic                 tbase_tick,
  input  wire logic                 rtc_tick,
  input  wire logic                 cycle_phase_two,
  input  wire logic                 stack_full,
  input  wire logic                 isr_exit_reenable,
  input  wire logic                 call_done,
  output svi_pkg::svi_call_t        call_q,
  output logic                      push_pc_q
);
  localparam int N = svi_pkg::NUM_SRC;

  function automatic logic [11:0] vec_of(input logic [2:0] s);
    case (s)
      3'h0:    vec_of = svi_pkg::VEC_EXT0;
      3'h1:    vec_of = svi_pkg::VEC_EXT1;
      3'h2:    vec_of = svi_pkg::VEC_TIMER0;
      3'h3:    vec_of = svi_pkg::VEC_TIMER1;
      3'h4:    vec_of = svi_pkg::VEC_TBASE;
      default: vec_of = svi_pkg::VEC_RTC;
    endcase
  endfunction

  typedef enum logic [1:0] {SVI_IDLE, SVI_CALL} svi_state_t;

  svi_state_t         state_q, state_d;
  logic               global_irq_enable_q, global_irq_enable_d;
  logic [N-1:0]       enable_q, enable_d;
  logic [N-1:0]       pending_q, pending_d;
  logic               pin_a_q, pin_b_q;
  logic [N-1:0]       hw_set;
  logic [N-1:0]       ready;
  logic [2:0]         winner;
  logic               any_ready;
  logic               wr_first, wr_second;
  logic [7:0]         rdata_d;
  logic               rvalid_d;
  svi_pkg::svi_call_t call_d;
  logic               push_pc_d;

  always_comb begin
    wr_first  = mem_req.wr_en &&
                (mem_req.addr == svi_pkg::ADDR_CTRL_FIRST);
    wr_second = mem_req.wr_en &&
                (mem_req.addr == svi_pkg::ADDR_CTRL_SECOND);
    hw_set[0] = pin_a_q & ~ext_pin_a;
    hw_set[1] = pin_b_q & ~ext_pin_b;
    hw_set[2] = timer0_overflow;
    hw_set[3] = timer1_overflow;
    hw_set[4] = tbase_tick;
    hw_set[5] = rtc_tick;
  end

  always_comb begin
    ready     = pending_q & enable_q;
    any_ready = |ready;
    winner    = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (ready[i]) begin
        winner = 3'(i);
      end
    end
  end

  always_comb begin
    state_d             = state_q;
    global_irq_enable_d = global_irq_enable_q;
    enable_d            = enable_q;
    pending_d           = pending_q;
    call_d              = call_q;
    push_pc_d           = 1'b0;
    if (wr_first) begin
      global_irq_enable_d = mem_req.wdata[svi_pkg::POS_GLOBAL_EN];
      enable_d[0] = mem_req.wdata[svi_pkg::POS_EXT0_EN];
      enable_d[1] = mem_req.wdata[svi_pkg::POS_EXT1_EN];
      enable_d[2] = mem_req.wdata[svi_pkg::POS_TIMER0_EN];
      pending_d[0] = mem_req.wdata[svi_pkg::POS_EXT0_PEND];
      pending_d[1] = mem_req.wdata[svi_pkg::POS_EXT1_PEND];
      pending_d[2] = mem_req.wdata[svi_pkg::POS_TIMER0_PEND];
    end
    if (wr_second) begin
      enable_d[3] = mem_req.wdata[svi_pkg::POS_TIMER1_EN];
      enable_d[4] = mem_req.wdata[svi_pkg::POS_TBASE_EN];
      enable_d[5] = mem_req.wdata[svi_pkg::POS_RTC_EN];
      pending_d[3] = mem_req.wdata[svi_pkg::POS_TIMER1_PEND];
      pending_d[4] = mem_req.wdata[svi_pkg::POS_TBASE_PEND];
      pending_d[5] = mem_req.wdata[svi_pkg::POS_RTC_PEND];
    end
    if (isr_exit_reenable) begin
      global_irq_enable_d = 1'b1;
    end
    case (state_q)
      SVI_IDLE: begin
        if (cycle_phase_two && global_irq_enable_q && any_ready &&
            !stack_full) begin
          pending_d[winner]   = 1'b0;
          global_irq_enable_d = 1'b0;
          call_d.take   = 1'b1;
          call_d.vector = vec_of(winner);
          call_d.source = winner;
          push_pc_d = 1'b1;
          state_d   = SVI_CALL;
        end
      end
      SVI_CALL: begin
        if (call_done) begin
          call_d.take = 1'b0;
          state_d     = SVI_IDLE;
        end
      end
      default: begin
        state_d = SVI_IDLE;
      end
    endcase
    pending_d = pending_d | hw_set;
  end

  always_comb begin
    rdata_d  = 8'h00;
    rvalid_d = mem_req.rd_en;
    if (mem_req.rd_en && mem_req.addr == svi_pkg::ADDR_CTRL_FIRST) begin
      rdata_d[svi_pkg::POS_GLOBAL_EN]   = global_irq_enable_q;
      rdata_d[svi_pkg::POS_EXT0_EN]     = enable_q[0];
      rdata_d[svi_pkg::POS_EXT1_EN]     = enable_q[1];
      rdata_d[svi_pkg::POS_TIMER0_EN]   = enable_q[2];
      rdata_d[svi_pkg::POS_EXT0_PEND]   = pending_q[0];
      rdata_d[svi_pkg::POS_EXT1_PEND]   = pending_q[1];
      rdata_d[svi_pkg::POS_TIMER0_PEND] = pending_q[2];
    end else if (mem_req.rd_en &&
                 mem_req.addr == svi_pkg::ADDR_CTRL_SECOND) begin
      // enable and pending flags, bits 3 and 7 zero
      rdata_d[svi_pkg::POS_TIMER1_EN]   = enable_q[3];
      rdata_d[svi_pkg::POS_TBASE_EN]    = enable_q[4];
      rdata_d[svi_pkg::POS_RTC_EN]      = enable_q[5];
      rdata_d[svi_pkg::POS_TIMER1_PEND] = pending_q[3];
      rdata_d[svi_pkg::POS_TBASE_PEND]  = pending_q[4];
      rdata_d[svi_pkg::POS_RTC_PEND]    = pending_q[5];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q             <= SVI_IDLE;
      global_irq_enable_q <= svi_pkg::RESET_CTRL_FIRST[0];
      enable_q            <= '0;
      pending_q           <= '0;
      pin_a_q             <= 1'b1;
      pin_b_q             <= 1'b1;
      rdata_q             <= 8'h00;
      rvalid_q            <= 1'b0;
      call_q              <= '0;
      push_pc_q           <= 1'b0;
    end else begin
      state_q             <= state_d;
      global_irq_enable_q <= global_irq_enable_d;
      enable_q            <= enable_d;
      pending_q           <= pending_d;
      pin_a_q             <= ext_pin_a;
      pin_b_q             <= ext_pin_b;
      rdata_q             <= rdata_d;
      rvalid_q            <= rvalid_d;
      call_q              <= call_d;
      push_pc_q           <= push_pc_d;
    end
  end
endmodule

// >>> verification/svi_unit_sva.sv
// assertion checker for the vectored interrupt unit
`timescale 1ns/1ps
module svi_unit_sva (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire svi_pkg::svi_mem_req_t mem_req,
  input wire logic [7:0]            rdata_q,
  input wire logic                  rvalid_q,
  input wire logic                  cycle_phase_two,
  input wire logic                  stack_full,
  input wire logic                  call_done,
  input wire svi_pkg::svi_call_t    call_q,
  input wire logic                  push_pc_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_read_answer: assert property (mem_req.rd_en |=> rvalid_q)
    else $error("read not answered");
  a_unmapped_zero: assert property (mem_req.rd_en
    && mem_req.addr != svi_pkg::ADDR_CTRL_FIRST
    && mem_req.addr != svi_pkg::ADDR_CTRL_SECOND |=> rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_top_bit_zero: assert property (rvalid_q |-> !rdata_q[7])
    else $error("unused bit set");
  a_accept_cause: assert property ($rose(call_q.take) |->
    $past(cycle_phase_two) && !$past(stack_full))
    else $error("accept without phase or with full stack");
  a_push_on_accept: assert property (push_pc_q |-> $rose(call_q.take))
    else $error("push outside accept");
  a_vector_map: assert property (call_q.take |->
    call_q.vector == ({9'h000, call_q.source} + 12'h001) << 2)
    else $error("wrong vector");
  a_take_hold: assert property (call_q.take && !call_done |=>
    call_q.take && $stable(call_q.source))
    else $error("call dropped early");
  a_take_end: assert property (call_q.take && call_done |=> !call_q.take)
    else $error("call not ended");
  c_rtc: cover property ($rose(call_q.take) && call_q.source == 3'h5);
  c_full: cover property (stack_full && cycle_phase_two);
  c_read: cover property (rvalid_q);
endmodule
bind svi_unit svi_unit_sva chk (.clk, .reset, .mem_req, .rdata_q, .rvalid_q,
  .cycle_phase_two, .stack_full, .call_done, .call_q, .push_pc_q);

// >>> verification/svi_seq_model.sv
// core sequencer model: phase pulse and call completion
`timescale 1ns/1ps
module svi_seq_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic take,
  output logic      phase_two,
  output logic      done
);
  logic [3:0] cnt;
  initial begin
    phase_two = 1'b0;
    done = 1'b0;
    cnt = 4'h0;
    forever begin
      @(posedge clk);
      #1;
      cnt = reset ? 4'h0 : cnt + 4'h1;
      phase_two = (cnt[1:0] == 2'h3);
      // completion delay varies from prompt to slow
      done = take && !done && (cnt[2:0] == 3'h5);
    end
  end
endmodule

// >>> verification/test_six_source_vectored_interrupt_unit.sv
// self-checking bench for the vectored interrupt unit
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error %0t: %h vs %h", $time, a, b); end end
module test_six_source_vectored_interrupt_unit;
  logic                  clk;
  logic                  reset;
  svi_pkg::svi_mem_req_t mem_req;
  logic [7:0]            rdata_q;
  logic                  rvalid_q;
  logic                  pin_a;
  logic                  pin_b;
  logic [3:0]            evt;
  logic                  phase_two;
  logic                  stack_full;
  logic                  isr_exit;
  logic                  call_done;
  svi_pkg::svi_call_t    call_q;
  logic [31:0]           rng;
  logic [5:0]            pend;
  int                    err_total;
  int                    num_checks;
  svi_unit uut (.clk(clk), .reset(reset), .mem_req(mem_req),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .ext_pin_a(pin_a),
    .ext_pin_b(pin_b), .timer0_overflow(evt[0]), .timer1_overflow(evt[1]),
    .tbase_tick(evt[2]), .rtc_tick(evt[3]), .cycle_phase_two(phase_two),
    .stack_full(stack_full), .isr_exit_reenable(isr_exit),
    .call_done(call_done), .call_q(call_q), .push_pc_q());
  svi_seq_model seq (.clk(clk), .reset(reset), .take(call_q.take),
    .phase_two(phase_two), .done(call_done));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  function automatic logic [2:0] first_src(input logic [5:0] m);
    first_src = 3'h0;
    for (int i = 5; i >= 0; i--) if (m[i]) first_src = 3'(i);
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    mem_req = '{1'b1, 1'b0, a, d};
    tick();
    mem_req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    tick();
    mem_req = '{1'b0, 1'b1, a, 8'h00};
    tick();
    mem_req = '0;
    `CHK(rdata_q, e)
  endtask
  task automatic wait_take(input logic v);
    int n;
    n = 0;
    while (call_q.take !== v && n < 60) begin
      tick();
      n++;
    end
    if (call_q.take !== v) begin
      err_total++;
      summarize();
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    mem_req = '0;
    pin_a = 1'b1;
    pin_b = 1'b1;
    evt = 4'h0;
    stack_full = 1'b0;
    isr_exit = 1'b0;
    rng = 32'h0195D8D2;
    err_total = 0;
    num_checks = 0;
    repeat (6) tick();
    reset = 1'b0;
    rd(svi_pkg::ADDR_CTRL_FIRST, 8'h00);
    rd(8'h20, 8'h00);
    wr(svi_pkg::ADDR_CTRL_SECOND, 8'hFF);
    rd(svi_pkg::ADDR_CTRL_SECOND, 8'h77);
    wr(svi_pkg::ADDR_CTRL_FIRST, 8'hFE);
    rd(svi_pkg::ADDR_CTRL_FIRST, 8'h7E);
    for (int r = 0; r < 6; r++) begin
      rng = xs(rng);
      pend = (r == 5) ? 6'h3F : rng[5:0] | (6'h01 << r);
      wr(svi_pkg::ADDR_CTRL_FIRST, 8'h00);
      wr(svi_pkg::ADDR_CTRL_SECOND, 8'h00);
      tick();
      pin_a = !pend[0];
      pin_b = !pend[1];
      evt = pend[5:2];
      tick();
      pin_a = 1'b1;
      pin_b = 1'b1;
      evt = 4'h0;
      rd(svi_pkg::ADDR_CTRL_FIRST, {1'b0, pend[2:0], 4'h0});
      rd(svi_pkg::ADDR_CTRL_SECOND, {1'b0, pend[5:3], 4'h0});
      stack_full = (r == 0);
      wr(svi_pkg::ADDR_CTRL_SECOND, {1'b0, pend[5:3], 4'h7});
      wr(svi_pkg::ADDR_CTRL_FIRST, {1'b0, pend[2:0], 4'hF});
      if (r == 0) begin
        repeat (10) tick();
        `CHK(call_q.take, 1'b0)
        stack_full = 1'b0;
      end
      while (pend != 6'h00) begin
        wait_take(1'b1);
        `CHK(call_q.source, first_src(pend))
        `CHK(call_q.vector, {7'h00, first_src(pend) + 3'h1, 2'h0})
        pend[first_src(pend)] = 1'b0;
        wait_take(1'b0);
        rd(svi_pkg::ADDR_CTRL_FIRST, {1'b0, pend[2:0], 4'hE});
        tick();
        isr_exit = 1'b1;
        tick();
        isr_exit = 1'b0;
      end
    end
    wr(svi_pkg::ADDR_CTRL_FIRST, 8'h00);
    tick();
    mem_req = '{1'b1, 1'b0, svi_pkg::ADDR_CTRL_FIRST, 8'h00};
    pin_a = 1'b0;
    tick();
    mem_req = '0;
    pin_a = 1'b1;
    rd(svi_pkg::ADDR_CTRL_FIRST, 8'h10);
    summarize();
  end
endmodule
